/* rtl/kbc_fifo.sv */
// Valid/ready FIFO for received serial bytes
// Single clock, synchronous active-high reset
module kbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,             // Clock
  input wire logic rst,             // Sync reset
  input wire logic in_valid,        // Write strobe
  output logic in_ready,            // Not full
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid,           // Not empty
  input wire logic out_ready,       // Read strobe
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic wr, rd;
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rp_q];
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_d = wr ? wp_q + 1'b1 : wp_q;
    rp_d = rd ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    if (wr) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : kbc_fifo

/* rtl/kbc_host_port.sv */
// Host port of a keyboard/auxiliary device controller: data and
// command/status byte ports, status flags, password lock.
// Assumes a receiver delivering bytes with parity/timeout flags and
// a transmitter accepting keyboard bytes; host access one strobe/cycle.
// Operation
// - Checked serial bytes appear at data port
// - Interrupt on byte, else hold for polling
// - Status read, command write at 64
// - Status bit 7 flags even parity
// - Status bit 6 on receive time-out
// - Transmit time-outs set only bit 6
// - Response parity error sets bits 6, 7
// - Bit 5 marks auxiliary byte in buffer
// - Bit 4 low while password lock active
// - Command write sets bit 3, data clears
// - Bit 2 mirrors system flag, reset zero
// - Bit 1 set on write, cleared when consumed
// - Bit 0 set on load, cleared on read
// - Output buffer is read-only eight bits
// - Data goes to keyboard unless parameter expected
// - Test command reports whether a password is stored
// - Load password while unlocked, replaces old one
// - Lock blocks data until keyboard matches pattern
// - Commands refused while lock active
// - Test answers FA stored, F1 none
// - Password bytes taken until zero byte
`include "kbc_params.svh"
module kbc_host_port (
  input wire logic CLK,            // 250 MHz clock
  input wire logic RST,            // Sync reset, active high
  input wire logic [7:0] ADDR,     // Host port address
  input wire logic RD,             // Host read strobe
  input wire logic WR,             // Host write strobe
  input wire logic [7:0] WDATA,    // Host write data
  output logic [7:0] RDATA,        // Host read data
  input wire logic RX_VALID,       // Received byte strobe
  output logic RX_READY,           // Receive FIFO not full
  input wire logic [7:0] RX_DATA,  // Received byte (translated)
  input wire logic RX_AUX,         // Byte came from aux device
  input wire logic RX_PAR_BAD,     // Byte had even parity
  input wire logic TMO_EVENT,      // Receive/transmit time-out
  output logic TX_VALID,           // Byte for the keyboard
  input wire logic TX_READY,       // Transmitter takes byte
  output logic [7:0] TX_DATA,      // Keyboard byte
  output logic KBD_IRQ,            // Keyboard/response interrupt
  output logic AUX_IRQ,            // Auxiliary interrupt
  output logic XLATE,              // Scan code translate enable
  output logic KBD_DIS,            // Keyboard interface disabled
  output logic AUX_DIS             // Aux interface disabled
);
  // ****************************************************
  // Declarations
  // ****************************************************
  kbc_pkg::kbc_state_t st_q, st_d;
  logic [7:0] obuf_q, obuf_d, ibuf_q, ibuf_d, cb_q, cb_d;
  logic [7:0] txd_q, txd_d, rdata_q, rdata_d;
  logic obf_q, obf_d, aux_q, aux_d, ibf_q, ibf_d, cd_q, cd_d;
  logic par_q, par_d, tmo_q, tmo_d, lock_q, lock_d;
  logic txv_q, txv_d;
  logic rsp_wait_q, rsp_wait_d;
  logic [7:0] pw_q [`KBC_PW_LEN];
  logic [7:0] pw_d [`KBC_PW_LEN];
  logic [3:0] pwn_q, pwn_d, mi_q, mi_d;
  logic f_valid, f_ready;
  logic [9:0] f_data;
  logic rd_data, wr_data, wr_cmd, resp;
  logic [7:0] resp_b;
  logic [7:0] status;

  // ****************************************************
  // Helper functions
  // ****************************************************
  function automatic logic sel(input logic [7:0] a, input logic [7:0] p);
    sel = (a == p);
  endfunction : sel

  function automatic logic has_pw(input logic [3:0] n);
    has_pw = (n != 4'd0);
  endfunction : has_pw

  function automatic logic ram_other(input logic [7:0] c);
    ram_other = !c[7] && c[5] && (c[4:0] != 5'h00);
  endfunction : ram_other

  // ****************************************************
  // Receive FIFO
  // ****************************************************
  kbc_fifo #(.WIDTH(10), .DEPTH(`KBC_FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(RX_VALID),
    .in_ready(RX_READY),
    .in_data({RX_PAR_BAD, RX_AUX, RX_DATA}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ****************************************************
  // Host access and status
  // ****************************************************
  always_comb begin
    rd_data = RD && sel(ADDR, `KBC_DATA_PORT);
    wr_data = WR && sel(ADDR, `KBC_DATA_PORT);
    wr_cmd = WR && sel(ADDR, `KBC_CMD_PORT);
    status = {par_q, tmo_q, aux_q, !lock_q, cd_q,
              cb_q[`KBC_CB_SYS], ibf_q, obf_q};
    rdata_d = rdata_q;
    if (RD && sel(ADDR, `KBC_CMD_PORT)) begin
      rdata_d = status;
    end else if (rd_data) begin
      rdata_d = obuf_q;
    end
  end

  // ****************************************************
  // Controller engine
  // ****************************************************
  always_comb begin
    st_d = st_q;
    obuf_d = obuf_q;
    obf_d = obf_q;
    aux_d = aux_q;
    ibuf_d = ibuf_q;
    ibf_d = ibf_q;
    cd_d = cd_q;
    cb_d = cb_q;
    par_d = par_q;
    tmo_d = tmo_q;
    lock_d = lock_q;
    txv_d = txv_q && !TX_READY;
    txd_d = txd_q;
    pw_d = pw_q;
    pwn_d = pwn_q;
    mi_d = mi_q;
    rsp_wait_d = rsp_wait_q;
    f_ready = 1'b0;
    resp = 1'b0;
    resp_b = 8'h00;
    if (TMO_EVENT) begin
      tmo_d = 1'b1;
    end
    // Input buffer consumed the cycle after it is written, unless a keyboard byte is pending
    if (ibf_q && !txv_q) begin
      ibf_d = 1'b0;
      if (cd_q) begin
        if (lock_q) begin
          // Ignored while locked
        end else if (ram_other(ibuf_q)) begin
          // Only the command byte of controller RAM is kept
        end else begin
          case (ibuf_q)
            `KBC_OP_RDCB: begin
              resp = 1'b1;
              resp_b = cb_q;
            end
            `KBC_OP_WRCB: st_d = kbc_pkg::KBC_WRCB;
            `KBC_OP_TSTPW: begin
              resp = 1'b1;
              resp_b = has_pw(pwn_q) ? `KBC_PW_YES :
                                       `KBC_PW_NO;
            end
            `KBC_OP_LDPW: begin
              pwn_d = 4'd0;
              st_d = kbc_pkg::KBC_LDPW;
            end
            `KBC_OP_ENPW: begin
              lock_d = has_pw(pwn_q);
              mi_d = 4'd0;
            end
            `KBC_OP_DAUX: cb_d[`KBC_CB_DAUX] = 1'b1;
            `KBC_OP_EAUX: cb_d[`KBC_CB_DAUX] = 1'b0;
            `KBC_OP_DKBD: cb_d[`KBC_CB_DKBD] = 1'b1;
            `KBC_OP_EKBD: cb_d[`KBC_CB_DKBD] = 1'b0;
            default: ;
          endcase
        end
      end else begin
        case (st_q)
          kbc_pkg::KBC_WRCB: begin
            cb_d = ibuf_q & 8'h77;
            st_d = kbc_pkg::KBC_IDLE;
          end
          kbc_pkg::KBC_LDPW: begin
            if (ibuf_q == 8'h00) begin
              st_d = kbc_pkg::KBC_IDLE;
            end else if (pwn_q != 4'(`KBC_PW_LEN)) begin
              pw_d[pwn_q[2:0]] = ibuf_q;
              pwn_d = pwn_q + 4'd1;
            end
          end
          default: begin
            txv_d = 1'b1;
            txd_d = ibuf_q;
          end
        endcase
      end
    end
    // Keyboard answer expected once a byte has been clocked out
    if (txv_q && TX_READY) begin
      rsp_wait_d = 1'b1;
    end
    // Received bytes: compared while locked, else loaded when empty
    if (f_valid && lock_q) begin
      f_ready = 1'b1;
      if (!f_data[8]) begin
        if (f_data[7:0] == pw_q[mi_q[2:0]]) begin
          mi_d = mi_q + 4'd1;
          if (mi_q + 4'd1 == pwn_q) begin
            lock_d = 1'b0;
            mi_d = 4'd0;
          end
        end else begin
          mi_d = 4'd0;
        end
      end
    end else if (resp && !obf_q) begin
      obuf_d = resp_b;
      obf_d = 1'b1;
      aux_d = 1'b0;
    end else if (f_valid && !obf_q && !resp) begin
      f_ready = 1'b1;
      obuf_d = f_data[7:0];
      obf_d = 1'b1;
      aux_d = f_data[8];
      par_d = f_data[9];
      if (!f_data[8]) begin
        rsp_wait_d = 1'b0;
        if (f_data[9] && rsp_wait_q) begin
          tmo_d = 1'b1;
        end
      end
    end
    if (rd_data && obf_q) begin
      obf_d = 1'b0;
    end
    if (wr_cmd || wr_data) begin
      ibuf_d = WDATA;
      ibf_d = 1'b1;
      cd_d = wr_cmd;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q <= kbc_pkg::KBC_IDLE;
      obuf_q <= 8'h00;
      obf_q <= 1'b0;
      aux_q <= 1'b0;
      ibuf_q <= 8'h00;
      ibf_q <= 1'b0;
      cd_q <= 1'b0;
      cb_q <= `KBC_CB_RESET;
      par_q <= 1'b0;
      tmo_q <= 1'b0;
      lock_q <= 1'b0;
      txv_q <= 1'b0;
      rsp_wait_q <= 1'b0;
      txd_q <= 8'h00;
      pwn_q <= 4'd0;
      mi_q <= 4'd0;
      rdata_q <= 8'h00;
      for (int i = 0; i < `KBC_PW_LEN; i++) begin
        pw_q[i] <= 8'h00;
      end
    end else begin
      st_q <= st_d;
      obuf_q <= obuf_d;
      obf_q <= obf_d;
      aux_q <= aux_d;
      ibuf_q <= ibuf_d;
      ibf_q <= ibf_d;
      cd_q <= cd_d;
      cb_q <= cb_d;
      par_q <= par_d;
      tmo_q <= tmo_d;
      lock_q <= lock_d;
      txv_q <= txv_d;
      rsp_wait_q <= rsp_wait_d;
      txd_q <= txd_d;
      pwn_q <= pwn_d;
      mi_q <= mi_d;
      rdata_q <= rdata_d;
      pw_q <= pw_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  always_comb begin
    RDATA = rdata_q;
    TX_VALID = txv_q;
    TX_DATA = txd_q;
    KBD_IRQ = obf_q && !aux_q && cb_q[`KBC_CB_EKBD];
    AUX_IRQ = obf_q && aux_q && cb_q[`KBC_CB_EAUX];
    XLATE = cb_q[`KBC_CB_XLAT];
    KBD_DIS = cb_q[`KBC_CB_DKBD];
    AUX_DIS = cb_q[`KBC_CB_DAUX];
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  obf_read_a: assert property (@(posedge CLK) disable iff (RST)
    rd_data && obf_q && !(f_valid && !lock_q) |=> !obf_q)
    else $error("output full not cleared by data read");
  cmd_flag_a: assert property (@(posedge CLK) disable iff (RST)
    wr_cmd |=> cd_q && ibf_q)
    else $error("command write did not set flags");
  data_flag_a: assert property (@(posedge CLK) disable iff (RST)
    wr_data |=> !cd_q && ibf_q)
    else $error("data write did not clear command flag");
  sys_mirror_a: assert property (@(posedge CLK) disable iff (RST)
    RD && sel(ADDR, `KBC_CMD_PORT) |=> RDATA[2] == $past(cb_q[2]))
    else $error("system flag not mirrored");
  lock_inh_a: assert property (@(posedge CLK) disable iff (RST)
    lock_q && ibf_q && cd_q && !txv_q |=> !resp && cb_q == $past(cb_q))
    else $error("command taken while locked");
  lock_out_a: assert property (@(posedge CLK) disable iff (RST)
    lock_q && !obf_q |=> !obf_q)
    else $error("data passed while locked");
  tmo_set_a: assert property (@(posedge CLK) disable iff (RST)
    TMO_EVENT |=> tmo_q)
    else $error("timeout not flagged");
  ibf_clear_a: assert property (@(posedge CLK) disable iff (RST)
    ibf_q && !txv_q && !WR |=> !ibf_q)
    else $error("input buffer not consumed");
  obf_load_a: assert property (@(posedge CLK) disable iff (RST)
    f_valid && !obf_q && !lock_q |=> obf_q)
    else $error("received byte not loaded");
  aux_flag_a: assert property (@(posedge CLK) disable iff (RST)
    f_valid && !obf_q && !lock_q && !resp |=> aux_q == $past(f_data[8]))
    else $error("aux flag wrong for loaded byte");
  rsp_par_a: assert property (@(posedge CLK) disable iff (RST)
    f_valid && !obf_q && !lock_q && !resp && !f_data[8] && f_data[9] &&
    rsp_wait_q |=> tmo_q && par_q)
    else $error("response parity error not flagged");
  inh_bit_a: assert property (@(posedge CLK) disable iff (RST)
    RD && sel(ADDR, `KBC_CMD_PORT) |=> RDATA[4] == !$past(lock_q))
    else $error("inhibit bit wrong");
  pw_test_a: assert property (@(posedge CLK) disable iff (RST)
    ibf_q && cd_q && !txv_q && !lock_q && ibuf_q == `KBC_OP_TSTPW &&
    !obf_q |=> obf_q && (obuf_q == `KBC_PW_YES || obuf_q == `KBC_PW_NO))
    else $error("password test code missing");
  pw_load_a: assert property (@(posedge CLK) disable iff (RST)
    ibf_q && cd_q && !txv_q && !lock_q && ibuf_q == `KBC_OP_LDPW |=>
    pwn_q == 4'd0 && st_q == kbc_pkg::KBC_LDPW)
    else $error("password load not started");
  pw_end_a: assert property (@(posedge CLK) disable iff (RST)
    st_q == kbc_pkg::KBC_LDPW && ibf_q && !cd_q && !txv_q &&
    ibuf_q == 8'h00 |=> st_q == kbc_pkg::KBC_IDLE)
    else $error("zero byte did not end password load");
  lock_drop_a: assert property (@(posedge CLK) disable iff (RST)
    lock_q && f_valid |-> f_ready)
    else $error("byte stalled while locked");
  tx_take_a: assert property (@(posedge CLK) disable iff (RST)
    st_q == kbc_pkg::KBC_IDLE && ibf_q && !cd_q && !txv_q |=>
    TX_VALID && TX_DATA == $past(ibuf_q))
    else $error("data byte not forwarded");
  tx_hold_a: assert property (@(posedge CLK) disable iff (RST)
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("keyboard byte dropped before taken");
  cb_mask_a: assert property (@(posedge CLK) disable iff (RST)
    st_q == kbc_pkg::KBC_WRCB && ibf_q && !cd_q && !txv_q |=>
    !cb_q[7] && !cb_q[3] && cb_q[2] == $past(ibuf_q[2]))
    else $error("command byte write wrong");
  rst_clear_a: assert property (@(posedge CLK)
    $past(RST) && !RST |-> !obf_q && !ibf_q && !tmo_q && !par_q)
    else $error("flags not clear after reset");
endmodule : kbc_host_port

/* rtl/kbc_params.svh */
// Constants of the keyboard/auxiliary controller host port
// Included by the host port design file; definitions only
`ifndef KBC_PARAMS_SVH
`define KBC_PARAMS_SVH
`define KBC_DATA_PORT 8'h60
`define KBC_CMD_PORT 8'h64
`define KBC_ST_PAR 7
`define KBC_ST_TMO 6
`define KBC_ST_AUX 5
`define KBC_ST_INH 4
`define KBC_ST_CMD 3
`define KBC_ST_SYS 2
`define KBC_ST_IBF 1
`define KBC_ST_OBF 0
`define KBC_CB_XLAT 6
`define KBC_CB_DAUX 5
`define KBC_CB_DKBD 4
`define KBC_CB_SYS 2
`define KBC_CB_EAUX 1
`define KBC_CB_EKBD 0
`define KBC_CB_RESET 8'h00
`define KBC_OP_RDCB 8'h20
`define KBC_OP_WRCB 8'h60
`define KBC_OP_TSTPW 8'hA4
`define KBC_OP_LDPW 8'hA5
`define KBC_OP_ENPW 8'hA6
`define KBC_OP_DAUX 8'hA7
`define KBC_OP_EAUX 8'hA8
`define KBC_OP_DKBD 8'hAD
`define KBC_OP_EKBD 8'hAE
`define KBC_PW_YES 8'hFA
`define KBC_PW_NO 8'hF1
`define KBC_PW_LEN 8
`define KBC_FIFO_DEPTH 8
`endif

/* rtl/kbc_pkg.sv */
// Types of the keyboard/auxiliary controller host port
// Needs nothing else
package kbc_pkg;
  typedef enum logic [1:0] {
    KBC_IDLE,
    KBC_WRCB,
    KBC_LDPW
  } kbc_state_t;
endpackage : kbc_pkg

/* verification/kbc_host_port_tb.sv */
// Self-checking bench of the host port: host byte bus by tasks,
// serial side by the model. Assumes read data one cycle after the strobe.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module kbc_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] d;
    logic a;
    logic [7:0] st;
  } kbc_row_t;
  logic CLK, RST, RD, WR, RX_VALID, RX_AUX, RX_PAR_BAD, TMO_EVENT, TX_READY;
  logic RX_READY, TX_VALID, KBD_IRQ, AUX_IRQ, XLATE, KBD_DIS, AUX_DIS;
  logic [7:0] ADDR, WDATA, RDATA, RX_DATA, TX_DATA;
  logic [3:0] tx_stall;
  int n_errors = 0;
  int num_checks = 0;
  kbc_row_t rows [4] = '{'{8'h1c, 1'b0, 8'h1d}, '{8'h80, 1'b1, 8'h3d},
                         '{8'hff, 1'b0, 8'h1d}, '{8'h00, 1'b1, 8'h3d}};
  kbc_host_port u_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .RD(RD), .WR(WR),
    .WDATA(WDATA), .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_DATA(RX_DATA), .RX_AUX(RX_AUX), .RX_PAR_BAD(RX_PAR_BAD),
    .TMO_EVENT(TMO_EVENT), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_DATA(TX_DATA), .KBD_IRQ(KBD_IRQ), .AUX_IRQ(AUX_IRQ), .XLATE(XLATE),
    .KBD_DIS(KBD_DIS), .AUX_DIS(AUX_DIS));
  kbc_kbd_model u_kbd (.clk(CLK), .rx_ready(RX_READY), .rx_valid(RX_VALID),
    .rx_data(RX_DATA), .rx_aux(RX_AUX), .rx_par_bad(RX_PAR_BAD),
    .tmo_event(TMO_EVENT), .tx_valid(TX_VALID), .tx_ready(TX_READY),
    .tx_data(TX_DATA), .tx_stall(tx_stall));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // **********************************
  // Host bus tasks
  // **********************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    #1;
    {ADDR, WDATA, WR} = {a, d, 1'b1};
    @(posedge CLK);
    #1;
    {WDATA, WR} = {~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge CLK);
    #1;
    {ADDR, RD} = {a, 1'b1};
    @(posedge CLK);
    #1;
    RD = 1'b0;
    q = RDATA;
  endtask : rd
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    for (int i = 0; i < 40; i++) begin
      rd(8'h64, s);
      if (s[b] === v) break;
    end
    if (s[b] !== v) begin
      n_errors++;
      $display("unexpected at %0t: status %h bit %0d exp %h", $time, s, b, v);
      report_and_stop();
    end
  endtask : wait_st
  task automatic cmd(input logic [7:0] c);
    wait_st(1, 1'b0);
    wr(8'h64, c);
  endtask : cmd
  task automatic dat(input logic [7:0] d);
    wait_st(1, 1'b0);
    wr(8'h60, d);
  endtask : dat
  // **********************************
  // Main sequence
  // **********************************
  initial begin
    logic [7:0] q;
    logic ok;
    int i;
    int n;
    {RST, RD, WR, ADDR, WDATA, tx_stall} = {3'b100, 16'h0000, 4'h8};
    repeat (4) @(posedge CLK);
    #1;
    RST = 1'b0;
    `CHK(RDATA, 8'h00)
    rd(8'h64, q);
    `CHK(q, 8'h10)
    $display("test reset done");
    cmd(8'h60);
    rd(8'h64, q);
    `CHK(q[3], 1'b1)
    dat(8'hcf);
    wait_st(1, 1'b0);
    rd(8'h64, q);
    `CHK(q[3:2], 2'b01)
    `CHK({XLATE, AUX_DIS, KBD_DIS}, 3'b100)
    cmd(8'h20);
    wait_st(0, 1'b1);
    rd(8'h60, q);
    `CHK(q, 8'h47)
    $display("test command byte done");
    for (i = 0; i < 4; i++) begin
      u_kbd.send(rows[i].d, rows[i].a, 1'b0, 20, ok);
      `CHK(ok, 1'b1)
      wait_st(0, 1'b1);
      rd(8'h64, q);
      `CHK(q, rows[i].st)
      `CHK({AUX_IRQ, KBD_IRQ}, {rows[i].a, ~rows[i].a})
      rd(8'h60, q);
      `CHK(q, rows[i].d)
      rd(8'h64, q);
      `CHK(q[0], 1'b0)
    end
    $display("test receive table done");
    dat(8'h5a);
    dat(8'h6b);
    rd(8'h64, q);
    `CHK(q[3:1], 3'b011)
    wait_st(1, 1'b0);
    `CHK(u_kbd.tx_last, 8'h5a)
    repeat (16) @(posedge CLK);
    `CHK({u_kbd.tx_count, u_kbd.tx_last}, {32'h0000_0002, 8'h6b})
    $display("test transmit done");
    n = 0;
    for (i = 0; i < 12; i++) begin
      u_kbd.send(8'(8'h40 + i), 1'b0, 1'b0, 4, ok);
      if (!ok) break;
      n++;
    end
    `CHK(n, 32'h0000_0009)
    for (i = 0; i < n; i++) begin
      wait_st(0, 1'b1);
      rd(8'h60, q);
      `CHK(q, 8'(8'h40 + i))
    end
    rd(8'h64, q);
    `CHK({RX_READY, q[0]}, 2'b10)
    $display("test fifo fill done");
    cmd(8'ha4);
    wait_st(0, 1'b1);
    rd(8'h60, q);
    `CHK(q, 8'hf1)
    cmd(8'ha5);
    dat(8'h1c);
    dat(8'h32);
    dat(8'h00);
    cmd(8'ha4);
    wait_st(0, 1'b1);
    rd(8'h60, q);
    `CHK(q, 8'hfa)
    cmd(8'ha6);
    wait_st(1, 1'b0);
    rd(8'h64, q);
    `CHK(q[4], 1'b0)
    cmd(8'ha4);
    wait_st(1, 1'b0);
    u_kbd.send(8'h11, 1'b1, 1'b0, 20, ok);
    u_kbd.send(8'h55, 1'b0, 1'b0, 20, ok);
    rd(8'h64, q);
    `CHK(q[4], 1'b0)
    `CHK(q[0], 1'b0)
    u_kbd.send(8'h1c, 1'b0, 1'b0, 20, ok);
    u_kbd.send(8'h32, 1'b0, 1'b0, 20, ok);
    repeat (10) @(posedge CLK);
    rd(8'h64, q);
    `CHK(q[4], 1'b1)
    `CHK(q[0], 1'b0)
    $display("test password done");
    dat(8'h33);
    repeat (16) @(posedge CLK);
    u_kbd.send(8'h77, 1'b0, 1'b1, 20, ok);
    wait_st(0, 1'b1);
    rd(8'h64, q);
    `CHK(q[7:6], 2'b11)
    rd(8'h60, q);
    `CHK(q, 8'h77)
    $display("test errors done");
    @(posedge CLK);
    #1;
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    RST = 1'b0;
    rd(8'h64, q);
    `CHK(q, 8'h10)
    u_kbd.tmo();
    rd(8'h64, q);
    `CHK(q[7:6], 2'b01)
    $display("test second reset done");
    report_and_stop();
  end
endmodule : kbc_host_port_tb

/* verification/kbc_kbd_model.sv */
// Serial-side stand-in: feeds received bytes and time-outs, takes
// keyboard bytes with a programmable stall. Receive side driven by task calls.
module kbc_kbd_model (
  input wire logic clk,              // Clock
  input wire logic rx_ready,         // Receive FIFO not full
  output logic rx_valid,             // Byte offered
  output logic [7:0] rx_data,        // Byte
  output logic rx_aux,               // From aux device
  output logic rx_par_bad,           // Even parity seen
  output logic tmo_event,            // Time-out pulse
  input wire logic tx_valid,         // Keyboard byte pending
  output logic tx_ready,             // Byte taken
  input wire logic [7:0] tx_data,    // Keyboard byte
  input wire logic [3:0] tx_stall    // Stall cycles before taking
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_last;
  int tx_count;
  initial begin
    {rx_valid, rx_aux, rx_par_bad, tmo_event} = 4'h0;
    rx_data = 8'h00;
  end
  // **********************************
  // Receive side
  // **********************************
  task automatic send(input logic [7:0] d, input logic a, input logic p,
                      input int tries, output logic ok);
    int i;
    i = 0;
    @(posedge clk);
    #1;
    {rx_valid, rx_data, rx_aux, rx_par_bad} = {1'b1, d, a, p};
    while (rx_ready !== 1'b1 && i < tries) begin
      @(posedge clk);
      #1;
      i++;
    end
    ok = (rx_ready === 1'b1);
    if (ok) begin
      @(posedge clk);
      #1;
    end
    {rx_valid, rx_data, rx_aux, rx_par_bad} = {1'b0, ~d, ~a, ~p};
  endtask : send
  task automatic tmo;
    @(posedge clk);
    #1;
    tmo_event = 1'b1;
    @(posedge clk);
    #1;
    tmo_event = 1'b0;
  endtask : tmo
  // **********************************
  // Transmit side
  // **********************************
  initial begin
    tx_ready = 1'b0;
    tx_count = 0;
    tx_last = 8'h00;
    forever begin
      @(posedge clk);
      #1;
      if (tx_valid === 1'b1) begin
        repeat (tx_stall) @(posedge clk);
        #1;
        tx_ready = 1'b1;
        @(posedge clk);
        tx_last = tx_data;
        tx_count++;
        #1;
        tx_ready = 1'b0;
      end
    end
  end
endmodule : kbc_kbd_model
